// File: shared/obdrmw_pkg.sv
// Constants and types shared by the on-chip bus decoder with read-modify-write support
package obdrmw_pkg;
  // Address map
  localparam logic [15:0] VEC_LO = 16'h0000;
  localparam logic [15:0] VEC_HI = 16'h002f;
  localparam logic [15:0] ROM_HI = 16'h7fff;
  localparam logic [15:0] IOS_LO = 16'hf770;
  localparam logic [15:0] IOS_HI = 16'hf77f;
  localparam logic [15:0] RAM_LO = 16'hfb80;
  localparam logic [15:0] RAM_HI = 16'hff7f;
  localparam logic [15:0] IOF_LO = 16'hffa0;
  localparam logic [15:0] IOF_HI = 16'hffff;
  localparam logic [15:0] SER3_LO = 16'hffa8;
  localparam logic [15:0] SER3_HI = 16'hffad;
  localparam logic [15:0] TM8_LO = 16'hffb8;
  localparam logic [15:0] TM8_HI = 16'hffbd;
  // Registers held inside this block
  localparam logic [15:0] TMR_ADDR = 16'hffb0;
  localparam logic [15:0] P3_LATCH_ADDR = 16'hffd0;
  localparam logic [15:0] P3_DIR_ADDR = 16'hffe0;
  // Memory geometry
  localparam int RAM_WORDS = 512;
  localparam int RAM_IDX_W = 9;
  // Access lengths in states, stored as states minus one
  localparam logic [1:0] FAST_CNT = 2'h1;
  localparam logic [1:0] SLOW_CNT = 2'h2;
  localparam logic [1:0] LAST_CNT = 2'h1;
  // Data values
  localparam logic [7:0] WO_READ = 8'hff;
  localparam logic [7:0] UNDEF_BYTE = 8'h00;
  localparam logic [7:0] TMR_TOP = 8'hff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [2:0] {RG_ROM, RG_RAM, RG_IO_SLOW, RG_IO_FAST, RG_EMPTY} obdrmw_region_t;
  typedef enum logic [2:0] {OP_NONE, OP_SET, OP_CLR, OP_INV, OP_ST, OP_IST} obdrmw_bitop_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ACC} obdrmw_phase_t;

  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
    obdrmw_bitop_t op;
    logic [2:0] bitsel;
    logic bitval;
  } obdrmw_cpu_req_t;

  typedef struct packed {
    logic ack;
    logic busy;
    logic [15:0] rdata;
  } obdrmw_cpu_rsp_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } obdrmw_per_req_t;
endpackage : obdrmw_pkg

// File: logic/obdrmw_bridge.sv
// CPU-side bus decoder: ROM, RAM, 8-bit peripheral area, port 3 and a reload timer
// How it works
// RL1: Writes to empty areas are dropped; nothing is stored.
// RL2: Reads from empty areas return an arbitrary filler value.
// RL3: Peripheral area transfers use an 8-bit data path.
// RL4: Word write to I/O keeps the upper byte, drops the lower byte.
// RL5: Word read from I/O puts the byte in the upper half, lower undefined.
// RL6: The CPU should use byte accesses for I/O registers.
// RL7: Compare timer, serial channel three and eight-bit timer ranges take three states.
// RL8: Bit operations read a byte, change one bit, write the byte back.
// RL9: Reload timer address reads the counter and writes the load register.
// RL10: Port data read returns pin level for input bits.
// RL11: Port data read returns latch value for output bits.
// RL12: Output pins drive their latch bit, changing right after the write.
// RL13: Software should keep a RAM shadow of port latches.
// RL14: Direction control reads back as all ones.
// RL15: ROM and RAM take two states over a 16-bit path, byte or word.
// RL16: Vectors and ROM low, RAM and I/O high, everything else empty.
// RL17: Direction bit one makes the pin an output, zero an input.
// RL18: Three states only inside the designated slow peripheral ranges.
`timescale 1ns/1ps
module obdrmw_bridge (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // CPU side
  input wire obdrmw_pkg::obdrmw_cpu_req_t i_cpu,
  output obdrmw_pkg::obdrmw_cpu_rsp_t o_cpu,
  // ROM macro
  output logic [15:0] o_rom_addr,
  input wire logic [15:0] i_rom_data,
  // Peripheral byte bus
  output obdrmw_pkg::obdrmw_per_req_t o_per,
  input wire logic [7:0] i_per_rdata,
  // Port 3 pins
  input wire logic [7:0] i_p3_pin,
  output logic [7:0] o_p3_out,
  output logic [7:0] o_p3_oe
);
  typedef struct packed {
    obdrmw_pkg::obdrmw_phase_t st;
    logic [1:0] cnt;
    logic [15:0] addr;
    logic we;
    logic word;
    logic rd_phase;
    obdrmw_pkg::obdrmw_bitop_t op;
    logic [2:0] bitsel;
    logic bitval;
    obdrmw_pkg::obdrmw_region_t region;
    logic [15:0] wbuf;
    logic [15:0] rdata;
    logic ack;
    logic [7:0] p3_latch;
    logic [7:0] p3_dir;
    logic [7:0] tmr_cnt;
    logic [7:0] tmr_load;
  } obdrmw_state_t;

  obdrmw_state_t s_r;
  obdrmw_state_t s_nxt;
  logic [15:0] ram [obdrmw_pkg::RAM_WORDS];
  logic [15:0] ram_off;
  logic [obdrmw_pkg::RAM_IDX_W-1:0] ram_idx;
  logic [15:0] ram_word;
  logic ram_we_hi;
  logic ram_we_lo;
  logic [15:0] ram_wdata;
  logic done;
  logic is_io;
  logic io_int;
  logic per_stb;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  logic [7:0] mod_byte;
  logic [15:0] mem_word;

  function automatic obdrmw_pkg::obdrmw_region_t decode(input logic [15:0] a);
    if (a <= obdrmw_pkg::ROM_HI) begin
      decode = obdrmw_pkg::RG_ROM; // RL16
    end else if (a >= obdrmw_pkg::IOS_LO && a <= obdrmw_pkg::IOS_HI) begin
      decode = obdrmw_pkg::RG_IO_SLOW; // RL7
    end else if (a >= obdrmw_pkg::RAM_LO && a <= obdrmw_pkg::RAM_HI) begin
      decode = obdrmw_pkg::RG_RAM;
    end else if (a >= obdrmw_pkg::SER3_LO && a <= obdrmw_pkg::SER3_HI) begin
      decode = obdrmw_pkg::RG_IO_SLOW; // RL7
    end else if (a >= obdrmw_pkg::TM8_LO && a <= obdrmw_pkg::TM8_HI) begin
      decode = obdrmw_pkg::RG_IO_SLOW; // RL7
    end else if (a >= obdrmw_pkg::IOF_LO) begin
      decode = obdrmw_pkg::RG_IO_FAST;
    end else begin
      decode = obdrmw_pkg::RG_EMPTY; // RL16
    end
  endfunction : decode

  assign ram_off = s_r.addr - obdrmw_pkg::RAM_LO;
  assign ram_idx = ram_off[obdrmw_pkg::RAM_IDX_W:1];
  assign ram_word = ram[ram_idx];
  assign done = (s_r.st == obdrmw_pkg::ST_ACC) && (s_r.cnt == obdrmw_pkg::LAST_CNT);
  assign is_io = (s_r.region == obdrmw_pkg::RG_IO_SLOW) || (s_r.region == obdrmw_pkg::RG_IO_FAST);
  assign io_int = (s_r.addr == obdrmw_pkg::P3_LATCH_ADDR) || (s_r.addr == obdrmw_pkg::P3_DIR_ADDR)
    || (s_r.addr == obdrmw_pkg::TMR_ADDR);
  assign per_stb = done && is_io && !io_int;

  // Byte bus strobes, one cycle in the last state of the access
  always_comb begin
    o_per.addr = s_r.addr;
    o_per.wdata = wr_byte; // RL3
    o_per.rd = per_stb && (!s_r.we || s_r.rd_phase);
    o_per.wr = per_stb && s_r.we && !s_r.rd_phase;
  end

  assign o_cpu.ack = s_r.ack;
  assign o_cpu.busy = (s_r.st != obdrmw_pkg::ST_IDLE);
  assign o_cpu.rdata = s_r.rdata;
  assign o_rom_addr = {s_r.addr[15:1], 1'b0};
  assign o_p3_out = s_r.p3_latch; // RL12
  assign o_p3_oe = s_r.p3_dir; // RL17
  // Word accesses ignore address bit 0; odd byte sits in the low lane
  assign mem_word = (s_r.region == obdrmw_pkg::RG_RAM) ? ram_word : i_rom_data; // RL15
  // Word write to I/O sends the upper byte only
  assign wr_byte = s_r.word ? s_r.wbuf[15:8] : s_r.wbuf[7:0]; // RL4

  // Byte seen by a read at the current address
  always_comb begin
    rd_byte = obdrmw_pkg::UNDEF_BYTE; // RL2
    if (s_r.region == obdrmw_pkg::RG_ROM || s_r.region == obdrmw_pkg::RG_RAM) begin
      rd_byte = s_r.addr[0] ? mem_word[7:0] : mem_word[15:8];
    end else if (is_io) begin
      if (s_r.addr == obdrmw_pkg::P3_LATCH_ADDR) begin
        rd_byte = (s_r.p3_dir & s_r.p3_latch) | (~s_r.p3_dir & i_p3_pin); // RL10 RL11
      end else if (s_r.addr == obdrmw_pkg::P3_DIR_ADDR) begin
        rd_byte = obdrmw_pkg::WO_READ; // RL14
      end else if (s_r.addr == obdrmw_pkg::TMR_ADDR) begin
        rd_byte = s_r.tmr_cnt; // RL9
      end else begin
        rd_byte = i_per_rdata;
      end
    end
  end

  // Modify step of the bit operations
  always_comb begin
    mod_byte = rd_byte;
    case (s_r.op)
      obdrmw_pkg::OP_SET: mod_byte[s_r.bitsel] = 1'b1; // RL8
      obdrmw_pkg::OP_CLR: mod_byte[s_r.bitsel] = 1'b0; // RL8
      obdrmw_pkg::OP_INV: mod_byte[s_r.bitsel] = ~rd_byte[s_r.bitsel]; // RL8
      obdrmw_pkg::OP_ST: mod_byte[s_r.bitsel] = s_r.bitval; // RL8
      obdrmw_pkg::OP_IST: mod_byte[s_r.bitsel] = ~s_r.bitval; // RL8
      default: mod_byte = rd_byte;
    endcase
  end

  // RAM lane enables; a word access writes both lanes
  always_comb begin
    ram_we_hi = 1'b0;
    ram_we_lo = 1'b0;
    ram_wdata = s_r.word ? s_r.wbuf : {s_r.wbuf[7:0], s_r.wbuf[7:0]};
    if (done && s_r.we && !s_r.rd_phase && s_r.region == obdrmw_pkg::RG_RAM) begin
      ram_we_hi = s_r.word || !s_r.addr[0]; // RL15
      ram_we_lo = s_r.word || s_r.addr[0]; // RL15
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    // Counter and load register share one address
    if (s_r.tmr_cnt == obdrmw_pkg::TMR_TOP) begin
      s_nxt.tmr_cnt = s_r.tmr_load; // RL9
    end else begin
      s_nxt.tmr_cnt = s_r.tmr_cnt + 8'h01;
    end
    case (s_r.st)
      obdrmw_pkg::ST_IDLE: begin
        if (i_cpu.req) begin
          s_nxt.st = obdrmw_pkg::ST_ACC;
          s_nxt.addr = i_cpu.addr;
          s_nxt.op = i_cpu.op;
          s_nxt.bitsel = i_cpu.bitsel;
          s_nxt.bitval = i_cpu.bitval;
          s_nxt.rd_phase = (i_cpu.op != obdrmw_pkg::OP_NONE); // RL8
          s_nxt.we = i_cpu.we || (i_cpu.op != obdrmw_pkg::OP_NONE);
          s_nxt.word = i_cpu.word && (i_cpu.op == obdrmw_pkg::OP_NONE);
          s_nxt.wbuf = i_cpu.wdata;
          s_nxt.region = decode(i_cpu.addr);
          // Slow ranges stretch to three states, all else two
          s_nxt.cnt = (decode(i_cpu.addr) == obdrmw_pkg::RG_IO_SLOW) ? obdrmw_pkg::SLOW_CNT
            : obdrmw_pkg::FAST_CNT; // RL7 RL18
        end
      end
      obdrmw_pkg::ST_ACC: begin
        if (!done) begin
          s_nxt.cnt = s_r.cnt - 2'h1;
        end else if (s_r.rd_phase) begin
          // Read half done; the write half reloads the same count, one state less than a full access
          s_nxt.rd_phase = 1'b0;
          s_nxt.wbuf = {obdrmw_pkg::UNDEF_BYTE, mod_byte}; // RL8
          s_nxt.cnt = (s_r.region == obdrmw_pkg::RG_IO_SLOW) ? obdrmw_pkg::SLOW_CNT
            : obdrmw_pkg::FAST_CNT; // RL18
        end else begin
          s_nxt.st = obdrmw_pkg::ST_IDLE;
          s_nxt.ack = 1'b1;
          if (s_r.we) begin
            // ROM and empty areas store nothing
            if (is_io && s_r.addr == obdrmw_pkg::P3_LATCH_ADDR) begin
              s_nxt.p3_latch = wr_byte; // RL12
            end else if (is_io && s_r.addr == obdrmw_pkg::P3_DIR_ADDR) begin
              s_nxt.p3_dir = wr_byte; // RL17
            end else if (is_io && s_r.addr == obdrmw_pkg::TMR_ADDR) begin
              s_nxt.tmr_load = wr_byte; // RL9
            end // RL1
          end else if (s_r.region == obdrmw_pkg::RG_EMPTY) begin
            s_nxt.rdata = {obdrmw_pkg::UNDEF_BYTE, obdrmw_pkg::UNDEF_BYTE}; // RL2
          end else if (s_r.word && is_io) begin
            s_nxt.rdata = {rd_byte, obdrmw_pkg::UNDEF_BYTE}; // RL5
          end else if (s_r.word) begin
            s_nxt.rdata = mem_word; // RL15
          end else begin
            s_nxt.rdata = {obdrmw_pkg::UNDEF_BYTE, rd_byte};
          end
        end
      end
      default: s_nxt.st = obdrmw_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      s_r <= '0;
      s_r.st <= obdrmw_pkg::ST_IDLE;
      s_r.op <= obdrmw_pkg::OP_NONE;
      s_r.region <= obdrmw_pkg::RG_EMPTY;
      s_r.p3_latch <= obdrmw_pkg::RST_BYTE;
      s_r.p3_dir <= obdrmw_pkg::RST_BYTE;
      s_r.rdata <= obdrmw_pkg::RST_WORD;
    end else begin
      s_r <= s_nxt;
    end
  end

  // RAM has no reset; contents are undefined until written
  always_ff @(posedge i_clk_sys) begin
    if (ram_we_hi) begin
      ram[ram_idx][15:8] <= ram_wdata[15:8];
    end
    if (ram_we_lo) begin
      ram[ram_idx][7:0] <= ram_wdata[7:0];
    end
  end
endmodule : obdrmw_bridge

// File: tb/obdrmw_far_model.sv
// Far-side model: ROM macro, byte-wide peripheral registers and port pins
`timescale 1ns/1ps
module obdrmw_far_model (
  // Clock
  input wire logic i_clk_sys,
  // ROM and peripheral bus
  input wire logic [15:0] i_rom_addr,
  output logic [15:0] o_rom_data,
  input wire obdrmw_pkg::obdrmw_per_req_t i_per,
  output logic [7:0] o_per_rdata,
  // Port pins
  input wire logic [7:0] i_p3_out,
  input wire logic [7:0] i_p3_oe,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_p3_pin
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;
  assign o_rom_data = ~i_rom_addr;
  // Off-cycle data inverts so a stale byte never passes
  assign o_per_rdata = i_per.rd ? mem[i_per.addr[7:0]] : ~last_r;
  assign o_p3_pin = (i_p3_out & i_p3_oe) | (i_ext & ~i_p3_oe);
  always @(posedge i_clk_sys) begin
    if (i_per.wr) mem[i_per.addr[7:0]] <= i_per.wdata;
    if (i_per.rd) last_r <= o_per_rdata;
  end
endmodule : obdrmw_far_model

// File: tb/obdrmw_bridge_monitor.sv
// Port checker for the on-chip bus decoder
`timescale 1ns/1ps
module obdrmw_bridge_monitor (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire obdrmw_pkg::obdrmw_cpu_req_t i_cpu,
  input wire obdrmw_pkg::obdrmw_cpu_rsp_t o_cpu,
  input wire logic [15:0] o_rom_addr,
  input wire logic [15:0] i_rom_data,
  input wire obdrmw_pkg::obdrmw_per_req_t o_per,
  input wire logic [7:0] i_per_rdata,
  input wire logic [7:0] i_p3_pin,
  input wire logic [7:0] o_p3_out,
  input wire logic [7:0] o_p3_oe
);
  logic [15:0] a;
  logic tk, pl, slow, ram, fio, emp, rb;
  assign a = i_cpu.addr;
  assign tk = i_cpu.req && !o_cpu.busy;
  assign pl = tk && i_cpu.op == obdrmw_pkg::OP_NONE;
  assign rb = pl && !i_cpu.we && !i_cpu.word;
  assign slow = a[15:4] == 12'hf77 || (a >= 16'hffa8 && a <= 16'hffad) || (a >= 16'hffb8 && a <= 16'hffbd);
  assign ram = a >= 16'hfb80 && a <= 16'hff7f;
  assign fio = a[15:3] == 13'h1ff4;
  assign emp = a[15:5] == 11'h7fc;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  ram_two_state_a: assert property (pl && ram |-> ##1 !o_cpu.ack ##1 o_cpu.ack)
    else $error("memory access not two states");
  slow_three_state_a: assert property (pl && slow |-> ##1 !o_cpu.ack [*2] ##1 o_cpu.ack)
    else $error("slow access not three states");
  fast_io_two_a: assert property (pl && fio |-> ##1 (o_per.rd || o_per.wr) ##1 o_cpu.ack)
    else $error("fast io access not two states");
  io_upper_byte_a: assert property (pl && fio && i_cpu.we && i_cpu.word |->
    ##1 o_per.wr && o_per.wdata == $past(i_cpu.wdata[15:8])) else $error("word write byte wrong");
  io_word_read_a: assert property (pl && fio && !i_cpu.we && i_cpu.word |->
    ##1 o_per.rd ##1 o_cpu.rdata == {$past(i_per_rdata), 8'h00}) else $error("word read layout wrong");
  empty_drop_a: assert property (pl && emp |=> !o_per.wr [*2])
    else $error("empty area write reached bus");
  bitop_rmw_a: assert property (tk && i_cpu.op != obdrmw_pkg::OP_NONE && fio |->
    ##1 o_per.rd ##1 o_per.wr && $stable(o_per.addr) ##1 o_cpu.ack) else $error("bit op not read then write");
  dir_ones_a: assert property (rb && a == 16'hffe0 |-> ##2 o_cpu.rdata == 16'h00ff)
    else $error("direction read not all ones");
  latch_drive_a: assert property (pl && i_cpu.we && !i_cpu.word && a == 16'hffd0 |->
    ##2 o_p3_out == $past(i_cpu.wdata[7:0], 2)) else $error("port latch not driven");
endmodule : obdrmw_bridge_monitor
bind obdrmw_bridge obdrmw_bridge_monitor i_mon (.i_clk_sys, .i_resetn, .i_cpu, .o_cpu, .o_rom_addr,
  .i_rom_data, .o_per, .i_per_rdata, .i_p3_pin, .o_p3_out, .o_p3_oe);

// File: tb/tb_top.sv
// Self-checking bench for the on-chip bus decoder
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  obdrmw_pkg::obdrmw_cpu_req_t cpu = '0;
  obdrmw_pkg::obdrmw_cpu_rsp_t rsp;
  obdrmw_pkg::obdrmw_per_req_t per;
  logic [15:0] rom_a, rom_d, rd;
  logic [7:0] prd, pin, p3o, p3e;
  logic [7:0] ext = 8'h40;
  int fail_count = 0;
  int num_checks = 0;
  int lat;
  obdrmw_bridge i_obdrmw_bridge (.i_clk_sys(clk), .i_resetn(rstn), .i_cpu(cpu), .o_cpu(rsp),
    .o_rom_addr(rom_a), .i_rom_data(rom_d), .o_per(per), .i_per_rdata(prd), .i_p3_pin(pin),
    .o_p3_out(p3o), .o_p3_oe(p3e));
  obdrmw_far_model i_obdrmw_far_model (.i_clk_sys(clk), .i_rom_addr(rom_a), .o_rom_data(rom_d),
    .i_per(per), .o_per_rdata(prd), .i_p3_out(p3o), .i_p3_oe(p3e), .i_ext(ext), .o_p3_pin(pin));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Entered 1 ns after an edge; request drops once taken, busy blocks a second take
  task automatic acc(input logic we, input logic wd, input logic [15:0] a, input logic [15:0] d = 16'h0000,
    input obdrmw_pkg::obdrmw_bitop_t op = obdrmw_pkg::OP_NONE, input logic [2:0] b = 3'h0);
    cpu = '{1'b1, we, wd, a, d, op, b, 1'b1};
    @(posedge clk);
    #1 cpu.req = 1'b0;
    chk({15'h0000, rsp.busy}, 16'h0001);
    lat = 0;
    while (rsp.ack !== 1'b1 && lat < 9) begin
      @(posedge clk);
      #1 lat++;
    end
    rd = rsp.rdata;
    chk({15'h0000, rsp.busy}, 16'h0000);
    if (lat > 8) chk(16'h0000, 16'h0001);
  endtask : acc
  task automatic t_mem;
    acc(1'b1, 1'b1, 16'hfb80, 16'h1234);
    acc(1'b0, 1'b1, 16'hfb81);
    chk(rd, 16'h1234);
    chk(16'(lat), 16'h0001);
    acc(1'b0, 1'b0, 16'hfb81);
    chk(rd, 16'h0034);
    acc(1'b0, 1'b1, 16'h0031);
    chk(rd, 16'hffcf);
    acc(1'b1, 1'b0, 16'hff90, 16'h00aa);
    acc(1'b0, 1'b0, 16'hff90);
    chk(16'(lat), 16'h0001);
  endtask : t_mem
  task automatic t_io;
    logic [15:0] sa [3] = '{16'hf770, 16'hffa8, 16'hffb8};
    acc(1'b1, 1'b1, 16'hffa0, 16'habcd);
    acc(1'b0, 1'b0, 16'hffa0);
    chk(rd, 16'h00ab);
    acc(1'b0, 1'b1, 16'hffa0);
    chk(rd, 16'hab00);
    chk(16'(lat), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 1'b0, sa[i], 16'h0050 + 16'(i));
      acc(1'b0, 1'b0, sa[i]);
      chk(rd, 16'h0050 + 16'(i));
      chk(16'(lat), 16'h0002);
    end
  endtask : t_io
  task automatic t_bits;
    for (int k = 1; k < 6; k++) begin
      acc(1'b1, 1'b0, 16'hfb85, 16'h005a);
      acc(1'b0, 1'b0, 16'hfb85, 16'h0000, obdrmw_pkg::obdrmw_bitop_t'(k), 3'h2);
      chk(16'(lat), 16'h0002);
      acc(1'b0, 1'b0, 16'hfb85);
      chk(rd, (k == 2 || k == 5) ? 16'h005a : 16'h005e);
    end
    acc(1'b0, 1'b0, 16'hffa0, 16'h0000, obdrmw_pkg::OP_INV, 3'h0);
    acc(1'b0, 1'b0, 16'hffa0);
    chk(rd, 16'h00aa);
  endtask : t_bits
  task automatic t_port;
    acc(1'b1, 1'b0, 16'hffe0, 16'h003f);
    chk({8'h00, p3e}, 16'h003f);
    acc(1'b0, 1'b0, 16'hffe0);
    chk(rd, 16'h00ff);
    acc(1'b1, 1'b0, 16'hffd0, 16'h0080);
    chk({8'h00, p3o}, 16'h0080);
    acc(1'b0, 1'b0, 16'hffd0);
    chk(rd, 16'h0040);
    acc(1'b0, 1'b0, 16'hffd0, 16'h0000, obdrmw_pkg::OP_SET, 3'h0);
    chk({8'h00, p3o}, 16'h0041);
    acc(1'b0, 1'b0, 16'hffe0, 16'h0000, obdrmw_pkg::OP_CLR, 3'h0);
    chk({8'h00, p3e}, 16'h00fe);
    // Shadow copy in RAM keeps latch bit 7 that a direct bit op on the port would lose
    acc(1'b1, 1'b0, 16'hfb90, 16'h0080);
    acc(1'b0, 1'b0, 16'hfb90, 16'h0000, obdrmw_pkg::OP_SET, 3'h0);
    acc(1'b0, 1'b0, 16'hfb90);
    chk(rd, 16'h0081);
    acc(1'b1, 1'b0, 16'hffd0, rd);
    chk({8'h00, p3o}, 16'h0081);
  endtask : t_port
  task automatic t_timer;
    acc(1'b1, 1'b0, 16'hffb0, 16'h00f0);
    repeat (300) @(posedge clk);
    #1 acc(1'b0, 1'b0, 16'hffb0);
    chk({4'h0, rd[15:4]}, 16'h000f);
  endtask : t_timer
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #50000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1 t_mem();
    t_io();
    t_bits();
    t_port();
    t_timer();
    give_verdict();
  end
endmodule : tb_top
